// ### pkg/ep_desc_regs.vh
`ifndef EP_DESC_REGS_VH
`define EP_DESC_REGS_VH

// Endpoint descriptor layout
`define EP_DESC_LEN         8'h07
`define EP_DESC_TYPE        8'h05
`define EP_OFS_LEN          3'h0
`define EP_OFS_TYPE         3'h1
`define EP_OFS_ADDR         3'h2
`define EP_OFS_ATTR         3'h3
`define EP_OFS_MPS_LO       3'h4
`define EP_OFS_MPS_HI       3'h5
`define EP_OFS_INTERVAL     3'h6

// Companion descriptor layout
`define COMP_DESC_LEN       8'h06
`define COMP_DESC_TYPE      8'h30
`define COMP_OFS_LEN        3'h0
`define COMP_OFS_TYPE       3'h1
`define COMP_OFS_BURST      3'h2
`define COMP_OFS_ATTR       3'h3
`define COMP_OFS_BPI_LO     3'h4
`define COMP_OFS_BPI_HI     3'h5

// Attribute byte fields
`define ATTR_XFER_LSB       0
`define ATTR_SYNC_LSB       2
`define ATTR_USAGE_LSB      4

// Transfer type codes
`define XFER_CONTROL        2'h0
`define XFER_ISO            2'h1
`define XFER_BULK           2'h2
`define XFER_INTR           2'h3

// Synchronisation codes
`define SYNC_NONE           2'h0

// Usage codes
`define USAGE_PERIODIC      2'h0
`define USAGE_NOTIFY        2'h1
`define USAGE_DATA          2'h0
`define USAGE_FEEDBACK      2'h1
`define USAGE_IMPLICIT      2'h2
`define USAGE_RESERVED      2'h3

// Burst field limit
`define BURST_MAX           4'hF

`endif

// ### rtl/ep_attr_encode.v
`include "ep_desc_regs.vh"

// Builds the attribute byte and the burst byte for one endpoint.
module ep_attr_encode (
    input  wire [1:0] xfer_type_in,
    input  wire [1:0] sync_type_in,
    input  wire       notify_only_in,
    input  wire       periodic_ever_in,
    input  wire       feedback_in,
    input  wire       implicit_fb_in,
    input  wire [3:0] burst_in,
    output reg  [7:0] attr_out,
    output reg  [7:0] burst_out,
    output reg        conflict_out
);
    reg [1:0] xfer;
    reg [1:0] sync;
    reg [1:0] usage;

    always @* begin
        xfer         = xfer_type_in;
        sync         = sync_type_in;
        usage        = 2'h0;
        conflict_out = 1'b0;
        if (feedback_in) begin
            // Explicit feedback forces iso and no sync
            conflict_out = (xfer_type_in != `XFER_ISO) ||
                           (sync_type_in != `SYNC_NONE) || implicit_fb_in;
            xfer  = `XFER_ISO;
            sync  = `SYNC_NONE;
            usage = `USAGE_FEEDBACK;
        end else if (xfer_type_in == `XFER_ISO) begin
            usage = implicit_fb_in ? `USAGE_IMPLICIT
                                   : `USAGE_DATA;
        end else if (xfer_type_in == `XFER_INTR) begin
            // Mixed-mode endpoints fall back to periodic
            sync  = `SYNC_NONE;
            usage = (notify_only_in && !periodic_ever_in) ? `USAGE_NOTIFY
                    : `USAGE_PERIODIC;
        end else begin
            sync  = `SYNC_NONE;
        end
        attr_out = {2'h0, usage, sync, xfer};
        // Control endpoints never burst
        if (xfer == `XFER_CONTROL)
            burst_out = 8'h00;
        else
            burst_out = {4'h0, burst_in};
    end
endmodule // ep_attr_encode

// ### rtl/ep_desc_server.v
`include "ep_desc_regs.vh"

module ep_desc_server #(
    parameter NUM_EP = 8
) (
    input  wire                clk_sys_in,
    input  wire                nrst_in,
    input  wire                gen_x_rate_in,
    input  wire                cfg_req_in,
    input  wire                ep_desc_req_in,
    input  wire                ep_cfg_wr_in,
    input  wire [2:0]          ep_cfg_idx_in,
    input  wire [3:0]          ep_num_in,
    input  wire                ep_dir_in_in,
    input  wire [1:0]          xfer_type_in,
    input  wire [1:0]          sync_type_in,
    input  wire                notify_only_in,
    input  wire                periodic_ever_in,
    input  wire                feedback_in,
    input  wire                implicit_fb_in,
    input  wire [3:0]          burst_in,
    input  wire [15:0]         max_pkt_in,
    input  wire [7:0]          interval_in,
    input  wire [NUM_EP-1:0]   ep_enable_in,
    input  wire                byte_ready_in,
    output reg  [7:0]          byte_out,
    output reg                 byte_valid_out,
    output reg                 byte_last_out,
    output reg                 busy_out,
    output reg                 refused_out,
    output reg                 cfg_error_out
);
    localparam ST_IDLE = 2'h0;
    localparam ST_EP   = 2'h1;
    localparam ST_COMP = 2'h2;

    reg [3:0]  num_reg   [0:NUM_EP-1];
    reg        dir_reg   [0:NUM_EP-1];
    reg [7:0]  attr_reg  [0:NUM_EP-1];
    reg [7:0]  burst_reg [0:NUM_EP-1];
    reg [15:0] mps_reg   [0:NUM_EP-1];
    reg [7:0]  ivl_reg   [0:NUM_EP-1];

    reg [1:0]  state_reg;
    reg [1:0]  state_next;
    reg [2:0]  idx_reg;
    reg [2:0]  idx_next;
    reg [2:0]  ofs_reg;
    reg [2:0]  ofs_next;
    reg        comp_en_reg;
    reg        valid_next;
    reg        last_next;
    reg [7:0]  byte_next;

    wire [7:0] enc_attr;
    wire [7:0] enc_burst;
    wire       enc_conflict;

    ep_attr_encode u_encode (
        .xfer_type_in     (xfer_type_in),
        .sync_type_in     (sync_type_in),
        .notify_only_in   (notify_only_in),
        .periodic_ever_in (periodic_ever_in),
        .feedback_in      (feedback_in),
        .implicit_fb_in   (implicit_fb_in),
        .burst_in         (burst_in),
        .attr_out         (enc_attr),
        .burst_out        (enc_burst),
        .conflict_out     (enc_conflict)
    );

    function [1:0] usage_of;
        input [7:0] attr;
        begin
            usage_of = attr[`ATTR_USAGE_LSB+1:`ATTR_USAGE_LSB];
        end
    endfunction

    function is_fb;
        input [7:0] attr;
        begin
            is_fb = (attr[1:0] == `XFER_ISO) &&
                    ((usage_of(attr) == `USAGE_FEEDBACK) ||
                     (usage_of(attr) == `USAGE_IMPLICIT));
        end
    endfunction

    // Endpoint table; default control pipe is never stored here
    integer i;
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (i = 0; i < NUM_EP; i = i + 1) begin
                num_reg[i]   <= 4'h0;
                dir_reg[i]   <= 1'b0;
                attr_reg[i]  <= 8'h00;
                burst_reg[i] <= 8'h00;
                mps_reg[i]   <= 16'h0000;
                ivl_reg[i]   <= 8'h00;
            end
        end else if (ep_cfg_wr_in && !busy_out) begin
            num_reg[ep_cfg_idx_in]   <= ep_num_in;
            dir_reg[ep_cfg_idx_in]   <= ep_dir_in_in;
            attr_reg[ep_cfg_idx_in]  <= enc_attr;
            burst_reg[ep_cfg_idx_in] <= enc_burst;
            mps_reg[ep_cfg_idx_in]   <= max_pkt_in;
            ivl_reg[ep_cfg_idx_in]   <= interval_in;
        end
    end

    // Association check: each iso data endpoint resolves to the nearest
    // feedback at or below its number, which must face the other way.
    // Writes are not blocked; the flag just reports a bad table.
    reg       assoc_bad;
    reg       found;
    reg       fb_dir;
    reg [3:0] best;
    integer   d;
    integer   f;
    always @* begin
        assoc_bad = 1'b0;
        found     = 1'b0;
        fb_dir    = 1'b0;
        best      = 4'h0;
        for (d = 0; d < NUM_EP; d = d + 1) begin
            found  = 1'b0;
            fb_dir = 1'b0;
            best   = 4'h0;
            for (f = 0; f < NUM_EP; f = f + 1) begin
                if (ep_enable_in[f] && ep_enable_in[d] && f != d &&
                    is_fb(attr_reg[f]) &&
                    num_reg[f] <= num_reg[d] &&
                    (!found || num_reg[f] >= best)) begin
                    found  = 1'b1;
                    best   = num_reg[f];
                    fb_dir = dir_reg[f];
                end
            end
            if (ep_enable_in[d] && attr_reg[d][1:0] == `XFER_ISO &&
                usage_of(attr_reg[d]) != `USAGE_FEEDBACK &&
                found && fb_dir == dir_reg[d])
                assoc_bad = 1'b1;
        end
        for (f = 0; f < NUM_EP; f = f + 1) begin
            // Group head must share the feedback's number
            found = 1'b0;
            for (d = 0; d < NUM_EP; d = d + 1) begin
                if (ep_enable_in[f] && ep_enable_in[d] &&
                    is_fb(attr_reg[f]) && f != d &&
                    num_reg[d] == num_reg[f] && dir_reg[d] != dir_reg[f])
                    found = 1'b1;
            end
            if (ep_enable_in[f] && is_fb(attr_reg[f]) &&
                usage_of(attr_reg[f]) == `USAGE_FEEDBACK && !found)
                assoc_bad = 1'b1;
            if (ep_enable_in[f] &&
                usage_of(attr_reg[f]) == `USAGE_RESERVED &&
                attr_reg[f][1:0] == `XFER_ISO)
                assoc_bad = 1'b1;
        end
    end

    // Next enabled slot strictly after the current index idx_reg
    reg [2:0] scan_idx;
    reg       scan_hit;
    integer   k;
    always @* begin
        scan_idx = 3'h0;
        scan_hit = 1'b0;
        for (k = NUM_EP - 1; k >= 0; k = k - 1) begin
            if (ep_enable_in[k] && k[2:0] > idx_reg) begin
                scan_idx = k[2:0];
                scan_hit = 1'b1;
            end
        end
    end

    reg [2:0] first_idx;
    reg       first_hit;
    integer   m;
    always @* begin
        first_idx = 3'h0;
        first_hit = 1'b0;
        for (m = NUM_EP - 1; m >= 0; m = m - 1) begin
            if (ep_enable_in[m]) begin
                first_idx = m[2:0];
                first_hit = 1'b1;
            end
        end
    end

    function [7:0] ep_byte;
        input [2:0] ofs;
        input [2:0] idx;
        begin
            case (ofs)
                `EP_OFS_LEN:      ep_byte = `EP_DESC_LEN;
                `EP_OFS_TYPE:     ep_byte = `EP_DESC_TYPE;
                `EP_OFS_ADDR:     ep_byte = {dir_reg[idx], 3'h0,
                                             num_reg[idx]};
                `EP_OFS_ATTR:     ep_byte = attr_reg[idx];
                `EP_OFS_MPS_LO:   ep_byte = mps_reg[idx][7:0];
                `EP_OFS_MPS_HI:   ep_byte = mps_reg[idx][15:8];
                `EP_OFS_INTERVAL: ep_byte = ivl_reg[idx];
                default:          ep_byte = 8'h00;
            endcase
        end
    endfunction

    function [7:0] comp_byte;
        input [2:0] ofs;
        input [2:0] idx;
        begin
            case (ofs)
                `COMP_OFS_LEN:   comp_byte = `COMP_DESC_LEN;
                `COMP_OFS_TYPE:  comp_byte = `COMP_DESC_TYPE;
                `COMP_OFS_BURST: comp_byte = burst_reg[idx];
                default:         comp_byte = 8'h00;
            endcase
        end
    endfunction

    // Byte stream walker; a byte advances only when the sink accepts it
    wire take = byte_valid_out && byte_ready_in;

    always @* begin
        state_next = state_reg;
        idx_next   = idx_reg;
        ofs_next   = ofs_reg;
        valid_next = byte_valid_out && !take;
        last_next  = byte_last_out;
        byte_next  = byte_out;
        case (state_reg)
            ST_IDLE: begin
                // Only a whole-configuration request starts the walk
                // A last byte still pending keeps the block busy
                if (cfg_req_in && first_hit &&
                    !byte_valid_out) begin
                    state_next = ST_EP;
                    idx_next   = first_idx;
                    ofs_next   = 3'h0;
                end
            end
            ST_EP: begin
                if (!byte_valid_out || take) begin
                    valid_next = 1'b1;
                    byte_next  = ep_byte(ofs_reg, idx_reg);
                    last_next  = (ofs_reg == `EP_OFS_INTERVAL) &&
                                 !comp_en_reg && !scan_hit;
                    if (ofs_reg == `EP_OFS_INTERVAL) begin
                        ofs_next = 3'h0;
                        if (comp_en_reg)
                            state_next = ST_COMP;
                        else if (scan_hit)
                            idx_next = scan_idx;
                        else
                            state_next = ST_IDLE;
                    end else begin
                        ofs_next = ofs_reg + 3'h1;
                    end
                end
            end
            ST_COMP: begin
                if (!byte_valid_out || take) begin
                    valid_next = 1'b1;
                    byte_next  = comp_byte(ofs_reg, idx_reg);
                    last_next  = (ofs_reg == `COMP_OFS_BPI_HI) && !scan_hit;
                    if (ofs_reg == `COMP_OFS_BPI_HI) begin
                        ofs_next = 3'h0;
                        if (scan_hit) begin
                            state_next = ST_EP;
                            idx_next   = scan_idx;
                        end else begin
                            state_next = ST_IDLE;
                        end
                    end else begin
                        ofs_next = ofs_reg + 3'h1;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (take && byte_last_out)
            last_next = 1'b0;
    end

    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg      <= ST_IDLE;
            idx_reg        <= 3'h0;
            ofs_reg        <= 3'h0;
            comp_en_reg    <= 1'b0;
            byte_out       <= 8'h00;
            byte_valid_out <= 1'b0;
            byte_last_out  <= 1'b0;
            busy_out       <= 1'b0;
            refused_out    <= 1'b0;
            cfg_error_out  <= 1'b0;
        end else begin
            state_reg      <= state_next;
            idx_reg        <= idx_next;
            ofs_reg        <= ofs_next;
            byte_out       <= byte_next;
            byte_valid_out <= valid_next;
            byte_last_out  <= last_next;
            busy_out       <= (state_next != ST_IDLE) || valid_next;
            // Rate is latched per walk so a stream never changes shape
            if (state_reg == ST_IDLE && cfg_req_in && !byte_valid_out)
                comp_en_reg <= gen_x_rate_in;
            // Direct companion requests get a refusal pulse
            refused_out    <= ep_desc_req_in;
            cfg_error_out  <= assoc_bad ||
                              (ep_cfg_wr_in && enc_conflict);
        end
    end
endmodule // ep_desc_server

// ### bench/ep_desc_checker.sv
`include "ep_desc_regs.vh"

module ep_desc_checker #(
    parameter NUM_EP = 8
) (
    input wire              clk_sys_in,
    input wire              nrst_in,
    input wire              gen_x_rate_in,
    input wire              cfg_req_in,
    input wire              ep_desc_req_in,
    input wire [NUM_EP-1:0] ep_enable_in,
    input wire              byte_ready_in,
    input wire [7:0]        byte_out,
    input wire              byte_valid_out,
    input wire              byte_last_out,
    input wire              busy_out,
    input wire              refused_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] pos_reg;
    logic       gx_reg;
    wire        take = byte_valid_out && byte_ready_in;
    // Companion bytes only follow when the rate was latched at walk start
    wire  [3:0] lim = gx_reg ? 4'hC : 4'h6;
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pos_reg <= 4'h0;
            gx_reg  <= 1'b0;
        end else if (!busy_out) begin
            pos_reg <= 4'h0;
            gx_reg  <= gen_x_rate_in;
        end else if (take) begin
            pos_reg <= (pos_reg == lim) ? 4'h0 : pos_reg + 4'h1;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    sequence s_start;
        cfg_req_in && !busy_out && (|ep_enable_in);
    endsequence
    sequence s_first;
        busy_out ##1 (byte_valid_out && byte_out == `EP_DESC_LEN);
    endsequence
    AST_START: assert property (s_start |=> s_first)
        else $error("walk did not open with an endpoint length byte");
    AST_HOLD: assert property (
        byte_valid_out && !byte_ready_in |=>
        byte_valid_out && $stable(byte_out))
        else $error("byte changed before it was taken");
    AST_REFUSE: assert property (
        ep_desc_req_in && !busy_out |=> refused_out && !byte_valid_out)
        else $error("standalone companion request not refused");
    AST_EP_LEN: assert property (
        byte_valid_out && pos_reg == 4'h0 |-> byte_out == `EP_DESC_LEN)
        else $error("descriptor boundary lost");
    AST_COMP_NEXT: assert property (
        byte_valid_out && pos_reg == 4'h7 |->
        byte_out == (gx_reg ? `COMP_DESC_LEN : `EP_DESC_LEN))
        else $error("companion presence wrong after endpoint");
    AST_COMP_TYPE: assert property (
        byte_valid_out && pos_reg == 4'h8 |-> byte_out == `COMP_DESC_TYPE)
        else $error("companion type byte wrong");
    AST_BURST: assert property (
        byte_valid_out && pos_reg == 4'h9 |-> byte_out <= 8'h0F)
        else $error("burst byte out of range");
    AST_USAGE: assert property (
        byte_valid_out && pos_reg == 4'h3 |->
        byte_out[5:4] != `USAGE_RESERVED && byte_out[7:6] == 2'h0)
        else $error("attribute byte uses reserved code");
    AST_FB_ISO: assert property (
        byte_valid_out && pos_reg == 4'h3 &&
        byte_out[1:0] == `XFER_ISO && byte_out[5:4] == `USAGE_FEEDBACK |->
        byte_out[3:2] == `SYNC_NONE)
        else $error("feedback endpoint has synchronisation");
    AST_LAST_END: assert property (
        byte_last_out && take |=> ##[0:2] !busy_out)
        else $error("walk kept running after last byte");
endmodule // ep_desc_checker

bind ep_desc_server ep_desc_checker #(.NUM_EP(NUM_EP)) chk (
    .clk_sys_in, .nrst_in, .gen_x_rate_in, .cfg_req_in,
    .ep_desc_req_in, .ep_enable_in, .byte_ready_in, .byte_out,
    .byte_valid_out, .byte_last_out, .busy_out, .refused_out
);

// ### bench/host_sink.sv
module host_sink (
    input  wire       clk_sys_in,
    input  wire [7:0] byte_out,
    input  wire       byte_valid_out,
    input  wire       byte_last_out,
    input  wire       slow_in,
    output logic      byte_ready_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got [$];
    int         last_at = 0;
    int         lasts = 0;
    logic [1:0] cnt = 2'h0;
    initial byte_ready_in = 1'b0;
    // Bytes are stored raw; interval is never interpreted
    always @(posedge clk_sys_in) begin
        if (byte_valid_out && byte_ready_in) begin
            got.push_back(byte_out);
            if (byte_last_out) begin
                lasts++;
                last_at = got.size();
            end
        end
        #1;
        // Slow mode stalls three cycles in four, like a busy host
        byte_ready_in <= !slow_in || cnt == 2'h3;
        cnt = cnt + 2'h1;
    end
endmodule // host_sink

// ### bench/tb_top.sv
`include "ep_desc_regs.vh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in, nrst_in, gen_x_rate_in, cfg_req_in, ep_desc_req_in;
    logic ep_cfg_wr_in, ep_dir_in_in, notify_only_in, periodic_ever_in;
    logic feedback_in, implicit_fb_in, byte_ready_in, slow;
    logic [2:0]  ep_cfg_idx_in;
    logic [3:0]  ep_num_in, burst_in;
    logic [1:0]  xfer_type_in, sync_type_in;
    logic [15:0] max_pkt_in;
    logic [7:0]  interval_in, ep_enable_in, byte_out;
    logic byte_valid_out, byte_last_out, busy_out, refused_out, cfg_error_out;
    int   mismatches = 0;
    int   checks = 0;
    // Slot table, slot 0 in the low bits
    logic [31:0] num_v = 32'h66543211;
    logic [31:0] bu_v  = 32'h01752F03;
    logic [15:0] xt_v  = 16'h54F5;
    logic [15:0] st_v  = 16'h3801;
    // Each data slot finds an opposite-facing feedback at or below its
    // number, the way the host searches for it
    logic [7:0]  dir_v = 8'h4E;
    logic [7:0]  no_v  = 8'h0C;
    logic [7:0]  pe_v  = 8'h08;
    logic [7:0]  fb_v  = 8'h82;
    logic [7:0]  im_v  = 8'h20;

    ep_desc_server #(.NUM_EP(8)) dut (.*);
    host_sink sink (.clk_sys_in(clk_sys_in), .byte_out(byte_out),
        .byte_valid_out(byte_valid_out), .byte_last_out(byte_last_out),
        .slow_in(slow), .byte_ready_in(byte_ready_in));

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    task check(input string name, input logic [7:0] seen,
               input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task cycle;
        @(posedge clk_sys_in);
        #1;
    endtask

    task automatic wr(input int i);
        cycle();
        ep_cfg_wr_in = 1'b1;
        ep_cfg_idx_in = 3'(i);
        ep_num_in = num_v[i*4+:4];
        ep_dir_in_in = dir_v[i];
        xfer_type_in = xt_v[i*2+:2];
        sync_type_in = st_v[i*2+:2];
        notify_only_in = no_v[i];
        periodic_ever_in = pe_v[i];
        feedback_in = fb_v[i];
        implicit_fb_in = im_v[i];
        burst_in = bu_v[i*4+:4];
        max_pkt_in = {8'h02, 5'h00, 3'(i)};
        interval_in = 8'(i + 1);
        cycle();
        ep_cfg_wr_in = 1'b0;
    endtask

    function automatic logic [7:0] ex_attr(input int i);
        logic [1:0] u;
        u = `USAGE_DATA;
        if (xt_v[i*2+:2] == `XFER_INTR)
            u = (no_v[i] && !pe_v[i]) ? `USAGE_NOTIFY : `USAGE_PERIODIC;
        else if (xt_v[i*2+:2] == `XFER_ISO && fb_v[i])
            u = `USAGE_FEEDBACK;
        else if (xt_v[i*2+:2] == `XFER_ISO && im_v[i])
            u = `USAGE_IMPLICIT;
        return {2'h0, u, st_v[i*2+:2], xt_v[i*2+:2]};
    endfunction

    task automatic walk(input logic gx, input logic [7:0] en, input logic sl);
        logic [7:0] exp [$];
        int n;
        sink.got.delete();
        sink.lasts = 0;
        slow = sl;
        gen_x_rate_in = gx;
        ep_enable_in = en;
        cycle();
        cfg_req_in = 1'b1;
        cycle();
        cfg_req_in = 1'b0;
        n = 0;
        while (busy_out !== 1'b0 && n < 3000) begin
            cycle();
            n++;
        end
        check("busy", {7'h00, busy_out}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            if (en[i]) begin
                exp.push_back(`EP_DESC_LEN);
                exp.push_back(`EP_DESC_TYPE);
                exp.push_back({dir_v[i], 3'h0, num_v[i*4+:4]});
                exp.push_back(ex_attr(i));
                exp.push_back(8'(i));
                exp.push_back(8'h02);
                exp.push_back(8'(i + 1));
                if (gx) begin
                    exp.push_back(`COMP_DESC_LEN);
                    exp.push_back(`COMP_DESC_TYPE);
                    exp.push_back(xt_v[i*2+:2] == `XFER_CONTROL ?
                                  8'h00 : {4'h0, bu_v[i*4+:4]});
                    exp.push_back(8'h00);
                    exp.push_back(8'h00);
                    exp.push_back(8'h00);
                end
            end
        end
        check("count", 8'(sink.got.size()), 8'(exp.size()));
        foreach (exp[k])
            if (k < sink.got.size())
                check("byte", sink.got[k],
                      exp[k]);
        check("last", 8'(sink.last_at), 8'(exp.size()));
        check("lasts", 8'(sink.lasts), 8'h01);
    endtask

    task refuse;
        sink.got.delete();
        cycle();
        ep_desc_req_in = 1'b1;
        cycle();
        ep_desc_req_in = 1'b0;
        check("refused", {7'h00, refused_out}, 8'h01);
        repeat (4) cycle();
        check("stream", 8'(sink.got.size()), 8'h00);
    endtask

    task assoc;
        // The table check only looks at slots that are present
        ep_enable_in = 8'hFF;
        for (int i = 0; i < 8; i++) wr(i);
        repeat (2) cycle();
        check("cfg_err", {7'h00, cfg_error_out}, 8'h00);
        dir_v[7] = 1'b1;
        wr(7);
        repeat (2) cycle();
        check("cfg_err", {7'h00, cfg_error_out}, 8'h01);
        dir_v[7] = 1'b0;
        wr(7);
        repeat (2) cycle();
        check("cfg_err", {7'h00, cfg_error_out}, 8'h00);
        // Clean table first, so only the conflicting write can raise it
        xt_v[15:14] = `XFER_BULK;
        wr(7);
        check("cfg_err", {7'h00, cfg_error_out}, 8'h01);
        xt_v[15:14] = `XFER_ISO;
    endtask

    initial begin
        {nrst_in, gen_x_rate_in, cfg_req_in, ep_desc_req_in, slow} = 5'h00;
        {ep_cfg_wr_in, ep_dir_in_in, notify_only_in, periodic_ever_in} = 4'h0;
        {feedback_in, implicit_fb_in, ep_cfg_idx_in, ep_num_in} = 9'h000;
        {xfer_type_in, sync_type_in, burst_in, interval_in} = 16'h0000;
        max_pkt_in = 16'h0000;
        ep_enable_in = 8'h00;
        repeat (20) cycle();
        check("reset", {4'h0, byte_valid_out, busy_out, refused_out,
              cfg_error_out}, 8'h00);
        nrst_in = 1'b1;
        assoc();
        refuse();
        walk(1'b1, 8'hFF, 1'b1);
        walk(1'b0, 8'h55, 1'b0);
        finish_test();
    end

    // Two walks, only the first with stalls, need well under 2000 cycles
    initial begin
        #300us;
        mismatches++;
        finish_test();
    end
endmodule // tb_top
